// file: bridge_pwm_pkg.sv
/*
  shared constants, types and helpers for the phase-shifted bridge pwm block.
  assumes a 100 MHz system clock; timer counts advance at a 60 MHz rate.
*/
package bridge_pwm_pkg;
  localparam int unsigned SYS_HZ = 100_000_000;
  localparam int unsigned TICK_HZ = 60_000_000;
  // fractional tick rate as num/den of sys_clk
  localparam logic [2:0] TICK_NUM = 3'(TICK_HZ / 20_000_000);
  localparam logic [2:0] TICK_DEN = 3'(SYS_HZ / 20_000_000);
  localparam logic [9:0] PERIOD_COUNTS = 10'd600;
  localparam logic [9:0] PERIOD_VALUE = 10'd599;
  localparam logic [9:0] HALF_COUNTS = 10'd300;
  localparam int unsigned PHASE_SHIFT = 25;
  localparam logic [2:0] ADC_SEQ_LEN = 3'd5;
  localparam logic [23:0] PHASE_MAX = 24'h00ff_ffff;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PHASE = 8'h04;
  localparam logic [7:0] OFS_DB_AP = 8'h08;
  localparam logic [7:0] OFS_DB_PA = 8'h0c;
  localparam logic [7:0] OFS_TRIP_DAC = 8'h10;
  localparam logic [7:0] OFS_VREF = 8'h14;
  localparam logic [7:0] OFS_IREF = 8'h18;
  localparam logic [7:0] OFS_GAIN = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_OFFSET = 8'h24;
  localparam logic [7:0] OFS_FEEDBACK = 8'h28;
  // reset values
  localparam logic [9:0] DB_RESET = 10'h014;
  localparam logic [9:0] TRIP_DAC_RESET = 10'h200;
  localparam logic [23:0] PHASE_RESET = 24'h0000;
  localparam logic [15:0] GAIN_RESET = 16'h0100;

  typedef enum logic [1:0] {
    RECT_DIODE = 2'b00,
    RECT_IDEAL = 2'b01,
    RECT_FULL = 2'b10
  } rect_mode_t;

  typedef enum logic {
    DIR_UP = 1'b0,
    DIR_DOWN = 1'b1
  } count_dir_t;

  typedef struct packed {
    logic closed_loop;
    logic current_loop;
    logic [1:0] rect_mode;
  } ctrl_t;

  typedef struct packed {
    logic leg_one_a;
    logic leg_one_b;
    logic leg_two_a;
    logic leg_two_b;
    logic rect_a;
    logic rect_b;
  } drive_t;

  // 12-bit converter result to q24
  function automatic logic [23:0] to_q24(input logic [11:0] raw);
    to_q24 = {raw, 12'h000};
  endfunction : to_q24

  // phase command times period value over 2^25
  function automatic logic [9:0] phase_to_offset(input logic [23:0] cmd);
    logic [33:0] prod;
    prod = 34'(cmd) * 34'(PERIOD_VALUE);
    phase_to_offset = 10'(prod >> PHASE_SHIFT);
  endfunction : phase_to_offset
endpackage : bridge_pwm_pkg

// file: dead_band.sv
/*
  rising-edge delay for a complementary output pair.
  assumes raw changes synchronously to sys_clk.
*/
module dead_band
  import bridge_pwm_pkg::*;
#(
  parameter int W = 10
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic raw,
  input wire logic [W-1:0] delay,
  output logic [1:0] drive
);
  logic [1:0] lvl;
  logic [W-1:0] cnt [2];

  assign lvl = {~raw, raw};

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (!resetn)
        cnt[i] <= '0;
      else if (!lvl[i])
        cnt[i] <= '0;
      else if (cnt[i] < delay)
        cnt[i] <= cnt[i] + 1'b1;
    end
  end

  always_comb
  begin
    for (int i = 0; i < 2; i++)
      drive[i] = lvl[i] && (cnt[i] >= delay);
  end
endmodule : dead_band

// file: feedback_loop.sv
/*
  per-period integrating controller producing the q24 phase command.
  assumes step pulses once per pwm period and feedback is q24.
*/
module feedback_loop
  import bridge_pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic step,
  input wire logic current_loop,
  input wire logic [23:0] vref,
  input wire logic [23:0] iref,
  input wire logic [23:0] v_fb,
  input wire logic [23:0] i_fb,
  input wire logic [15:0] gain,
  output logic [23:0] phase_cmd
);
  logic [23:0] vref_slewed;
  logic signed [25:0] err;
  logic signed [42:0] next_integ;
  logic signed [42:0] integ;

  // reference walks 0x100 q24 counts per period
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      vref_slewed <= '0;
    else if (step && vref_slewed < vref)
      vref_slewed <= vref_slewed + 24'h00_0100;
    else if (step && vref_slewed > vref)
      vref_slewed <= vref_slewed - 24'h00_0100;
  end

  always_comb
  begin
    if (current_loop)
      err = $signed({2'b00, iref}) - $signed({2'b00, i_fb});
    else
      err = $signed({2'b00, vref_slewed}) - $signed({2'b00, v_fb});
    next_integ = integ + 43'(err * $signed({1'b0, gain}) >>> 8);
    if (next_integ < 0)
      next_integ = '0;
    else if (next_integ > 43'(PHASE_MAX))
      next_integ = 43'(PHASE_MAX);
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      integ <= '0;
    else if (step)
      integ <= next_integ;
  end

  assign phase_cmd = integ[23:0];
endmodule : feedback_loop

// file: phase_shift_bridge_pwm_trip.sv
/*
  phase-shifted full-bridge pwm with synchronous rectifier drive and latched trip.
  assumes a 100 MHz sys_clk, an asynchronous comparator pin, and an external
  converter returning 12-bit results tagged with their sequence index.
*/
// The address-and-strobe port and the register offsets were chosen for this implementation.
// Overview of operation
// - timers count at 60 MHz, 600 per period
// - legs count up, rectifier counts up-down
// - leg outputs complementary at 50 percent
// - second leg phase adjustable while running
// - offset is command times 599 over 2^25
// - larger command gives longer diagonal overlap
// - one overlap per diagonal per period
// - control pulse and offset load at zero
// - outputs map to the numbered switches
// - second leg triggers five conversions per period
// - trigger at middle of diagonal overlap
// - 12-bit results rescaled to q24
// - 10-bit threshold level for the comparator
// - comparator trips all three timers
// - trip forces all six outputs low on the fourth clock edge after the comparator input rises
// - outputs stay low until device reset
// - separate dead bands per bridge leg
// - loop compares reference, sets phase command
// - rectifier mode zero holds rectifiers off; reset runs mode two until the first turning point
// - mode one: on during matching overlap
// - mode two: off during opposite overlap
// - mode and phase changes glitch free
module phase_shift_bridge_pwm_trip
  import bridge_pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [11:0] adc_data,
  input wire logic [2:0] adc_index,
  input wire logic adc_valid,
  input wire logic comp_trip,
  output logic [9:0] dac_level,
  output logic conversion_trigger_a,
  output logic count_zero_event,
  output logic leg_one_out_a,
  output logic leg_one_out_b,
  output logic leg_two_out_a,
  output logic leg_two_out_b,
  output logic rectifier_out_a,
  output logic rectifier_out_b
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  ctrl_t ctrl;
  logic [23:0] phase_reg;
  logic [9:0] active_passive_deadband;
  logic [9:0] passive_active_deadband;
  logic [23:0] vref;
  logic [23:0] iref;
  logic [15:0] gain;
  logic [23:0] adc_q24 [5];
  logic [23:0] loop_cmd;
  logic [23:0] phase_cmd;
  logic [9:0] leg_two_phase_offset;
  logic [9:0] rectifier_phase_offset;
  logic [9:0] leg_one_count;
  logic [9:0] leg_two_count;
  logic [9:0] rect_count;
  count_dir_t rect_dir;
  rect_mode_t rect_mode;
  logic [2:0] tick_acc;
  logic tick;
  logic [2:0] trip_sync;
  logic tripped;
  logic trip_now;
  logic ov_24;
  logic ov_13;
  logic [1:0] leg_one_db;
  logic [1:0] leg_two_db;
  drive_t next_drive;
  drive_t drive;

  logic [9:0] dac_reg;

  assign dac_level = dac_reg;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl <= '0;
      phase_reg <= PHASE_RESET;
      active_passive_deadband <= DB_RESET;
      passive_active_deadband <= DB_RESET;
      dac_reg <= TRIP_DAC_RESET;
      vref <= '0;
      iref <= '0;
      gain <= GAIN_RESET;
    end
    else if (wr)
    begin
      case (addr)
        OFS_CTRL: ctrl <= ctrl_t'(wdata[3:0]);
        OFS_PHASE: phase_reg <= wdata[23:0];
        OFS_DB_AP: active_passive_deadband <= wdata[9:0];
        OFS_DB_PA: passive_active_deadband <= wdata[9:0];
        OFS_TRIP_DAC: dac_reg <= wdata[9:0];
        OFS_VREF: vref <= wdata[23:0];
        OFS_IREF: iref <= wdata[23:0];
        OFS_GAIN: gain <= wdata[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rdata <= '0;
    else if (rd)
    begin
      case (addr)
        OFS_CTRL: rdata <= {28'h000_0000, ctrl};
        OFS_PHASE: rdata <= {8'h00, phase_reg};
        OFS_DB_AP: rdata <= {22'h00_0000, active_passive_deadband};
        OFS_DB_PA: rdata <= {22'h00_0000, passive_active_deadband};
        OFS_TRIP_DAC: rdata <= {22'h00_0000, dac_reg};
        OFS_VREF: rdata <= {8'h00, vref};
        OFS_IREF: rdata <= {8'h00, iref};
        OFS_GAIN: rdata <= {16'h0000, gain};
        OFS_STATUS: rdata <= {6'h00, leg_one_count, 15'h0000, tripped};
        OFS_OFFSET: rdata <= {6'h00, rectifier_phase_offset, 6'h00, leg_two_phase_offset};
        OFS_FEEDBACK: rdata <= {8'h00, adc_q24[0]};
        default: rdata <= '0;
      endcase
    end
    else
      rdata <= '0;
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  // 60 MHz count rate from the 100 MHz clock
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      tick_acc <= '0;
    else if (tick_acc + TICK_NUM >= TICK_DEN)
      tick_acc <= tick_acc + TICK_NUM - TICK_DEN;
    else
      tick_acc <= tick_acc + TICK_NUM;
  end

  assign tick = (tick_acc + TICK_NUM >= TICK_DEN);
  assign count_zero_event = tick && (leg_one_count == PERIOD_VALUE);

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      leg_one_count <= '0;
    else if (tick)
      leg_one_count <= (leg_one_count == PERIOD_VALUE) ? 10'd0 : leg_one_count + 10'd1;
  end

  // offset is loaded with the zero of the first leg
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      leg_two_count <= '0;
    else if (count_zero_event)
      leg_two_count <= leg_two_phase_offset;
    else if (tick)
      leg_two_count <= (leg_two_count == PERIOD_VALUE) ? 10'd0 : leg_two_count + 10'd1;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rect_count <= '0;
      rect_dir <= DIR_UP;
    end
    else if (count_zero_event)
    begin
      rect_count <= rectifier_phase_offset;
      rect_dir <= DIR_UP;
    end
    else if (tick)
    begin
      case (rect_dir)
        DIR_UP:
        begin
          rect_count <= rect_count + 10'd1;
          if (rect_count == HALF_COUNTS - 10'd1)
            rect_dir <= DIR_DOWN;
        end
        DIR_DOWN:
        begin
          rect_count <= rect_count - 10'd1;
          if (rect_count == 10'd1)
            rect_dir <= DIR_UP;
        end
        default: rect_dir <= DIR_UP;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // phase command and converter results
  // ----------------------------------------------------------------
  // results to q24
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 5; i++)
        adc_q24[i] <= '0;
    end
    else if (adc_valid && adc_index < ADC_SEQ_LEN)
      adc_q24[adc_index] <= to_q24(adc_data);
  end

  feedback_loop u_loop (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .step(count_zero_event),
    .current_loop(ctrl.current_loop),
    .vref(vref),
    .iref(iref),
    .v_fb(adc_q24[0]),
    .i_fb(adc_q24[1]),
    .gain(gain),
    .phase_cmd(loop_cmd)
  );

  // controller output drives the phase command when closed_loop is set, else phase_reg does
  assign phase_cmd = ctrl.closed_loop ? loop_cmd : phase_reg;

  // new offsets computed each period without stopping
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      leg_two_phase_offset <= '0;
      rectifier_phase_offset <= '0;
    end
    else if (count_zero_event)
    begin
      leg_two_phase_offset <= phase_to_offset(phase_cmd);
      rectifier_phase_offset <= phase_to_offset(phase_cmd) >> 1;
    end
  end

  // ----------------------------------------------------------------
  // bridge and rectifier waveforms
  // ----------------------------------------------------------------
  // diagonal overlap of the 50 percent raw leg waveforms
  assign ov_24 = (leg_one_count < HALF_COUNTS) && (leg_two_count >= HALF_COUNTS);
  // overlap length equals the offset, once per period
  assign ov_13 = (leg_one_count >= HALF_COUNTS) && (leg_two_count < HALF_COUNTS);

  dead_band u_db_one (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .raw(leg_one_count < HALF_COUNTS),
    .delay(active_passive_deadband),
    .drive(leg_one_db)
  );

  dead_band u_db_two (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .raw(leg_two_count < HALF_COUNTS),
    .delay(passive_active_deadband),
    .drive(leg_two_db)
  );

  // mode is taken only at the rectifier turning point
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      rect_mode <= RECT_FULL;
    else if (tick && rect_dir == DIR_DOWN && rect_count == 10'd1)
      rect_mode <= rect_mode_t'(ctrl.rect_mode);
  end

  always_comb
  begin
    next_drive.leg_one_a = leg_one_db[0];
    next_drive.leg_one_b = leg_one_db[1];
    next_drive.leg_two_a = leg_two_db[0];
    next_drive.leg_two_b = leg_two_db[1];
    case (rect_mode)
      RECT_DIODE:
      begin
        next_drive.rect_a = 1'b0;
        next_drive.rect_b = 1'b0;
      end
      RECT_IDEAL:
      begin
        next_drive.rect_a = ov_24;
        next_drive.rect_b = ov_13;
      end
      RECT_FULL:
      begin
        next_drive.rect_a = !ov_13;
        next_drive.rect_b = !ov_24;
      end
      default:
      begin
        next_drive.rect_a = 1'b0;
        next_drive.rect_b = 1'b0;
      end
    endcase
    if (trip_now)
      next_drive = '0;
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      drive <= '0;
    else
      drive <= next_drive;
  end

  assign leg_one_out_a = drive.leg_one_a;
  assign leg_one_out_b = drive.leg_one_b;
  assign leg_two_out_a = drive.leg_two_a;
  assign leg_two_out_b = drive.leg_two_b;
  assign rectifier_out_a = drive.rect_a;
  assign rectifier_out_b = drive.rect_b;

  // one trigger at middle of the overlap
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      conversion_trigger_a <= 1'b0;
    else
      conversion_trigger_a <= tick && !trip_now && !count_zero_event
        && (leg_two_count == HALF_COUNTS + (leg_two_phase_offset >> 1));
  end

  // ----------------------------------------------------------------
  // trip
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      trip_sync <= '0;
    else
      trip_sync <= {trip_sync[1:0], comp_trip};
  end

  // one-shot latch on all three timers
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      tripped <= 1'b0;
    else if (trip_sync[2] && trip_sync[1])
      tripped <= 1'b1;
  end

  assign trip_now = tripped || (trip_sync[2] && trip_sync[1]);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [9:0] zero_gap;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      zero_gap <= '0;
    else if (count_zero_event)
      zero_gap <= '0;
    else if (zero_gap != 10'h3ff)
      zero_gap <= zero_gap + 10'd1;
  end

  a_period_length: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    count_zero_event && $past(count_zero_event, 2) == 1'b0 && zero_gap != 10'h3ff
      |-> zero_gap == 10'd999)
    else $error("period is not 1000 clock cycles");

  a_trip_outputs_low: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    trip_sync[2] && trip_sync[1] |=> drive == '0)
    else $error("outputs not low after trip");

  a_trip_held: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    tripped |=> tripped && drive == '0)
    else $error("trip released before reset");

  a_leg_one_pair: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    !(leg_one_out_a && leg_one_out_b) && !(leg_two_out_a && leg_two_out_b))
    else $error("both outputs of a leg high");

  a_offset_load: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    count_zero_event |=> leg_two_phase_offset == phase_to_offset($past(phase_cmd)))
    else $error("offset formula mismatch");

  a_leg_two_sync: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    count_zero_event |=> leg_two_count == $past(leg_two_phase_offset) && leg_one_count == 10'd0)
    else $error("second leg not aligned at boundary");

  a_rect_diode: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    rect_mode == RECT_DIODE ##1 rect_mode == RECT_DIODE |-> !rectifier_out_a && !rectifier_out_b)
    else $error("rectifier on in diode mode");

  a_leg_up_count: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    tick && !count_zero_event |=> leg_one_count == $past(leg_one_count) + 10'd1)
    else $error("first leg not counting up");

  a_trigger_pulse: assert property (
    @(posedge sys_clk) disable iff (!resetn)
    conversion_trigger_a |=> !conversion_trigger_a [*2])
    else $error("conversion trigger longer than one cycle");
endmodule : phase_shift_bridge_pwm_trip

// file: converter_model.sv
/*
  converter and gate-driver model at the far side of the bridge pwm block.
  assumes one trigger starts a burst of results and gates are sampled on sys_clk.
*/
module converter_model
  import bridge_pwm_pkg::*;
#(
  parameter logic [11:0] V_RAW = 12'h05a3,
  parameter logic [11:0] I_RAW = 12'h02c7
)
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic trigger,
  input wire drive_t gates,
  output logic [11:0] adc_data,
  output logic [2:0] adc_index,
  output logic adc_valid,
  output logic shoot_through
);
  logic [2:0] left;
  logic [2:0] gap;

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      left <= 3'h0;
      gap <= 3'h0;
      adc_valid <= 1'b0;
      adc_index <= 3'h0;
      adc_data <= 12'h0000;
    end
    else if (trigger)
    begin
      left <= ADC_SEQ_LEN;
      gap <= 3'h7;
      adc_valid <= 1'b0;
    end
    else if (left != 3'h0 && gap == 3'h0)
    begin
      adc_valid <= 1'b1;
      adc_index <= ADC_SEQ_LEN - left;
      adc_data <= (left == ADC_SEQ_LEN) ? V_RAW : I_RAW;
      left <= left - 3'h1;
      gap <= 3'h7;
    end
    else
    begin
      // released bus shows inverted data
      adc_valid <= 1'b0;
      adc_data <= ~adc_data;
      if (gap != 3'h0)
        gap <= gap - 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      shoot_through <= 1'b0;
    else if ((gates.leg_one_a && gates.leg_one_b) || (gates.leg_two_a && gates.leg_two_b))
      shoot_through <= 1'b1;
  end
endmodule : converter_model

// file: tb.sv
/*
  self-checking bench for the phase-shifted bridge pwm block.
  assumes converter_model answers triggers; the bench drives bus and comparator.
*/
module tb
  import bridge_pwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] V_RAW = 12'h05a3;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic comp_trip = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata, rv;
  logic [11:0] adc_data;
  logic [2:0] adc_index;
  logic adc_valid, shoot;
  logic [9:0] dac_level;
  logic conversion_trigger_a, count_zero_event;
  logic leg_one_out_a, leg_one_out_b, leg_two_out_a, leg_two_out_b;
  logic rectifier_out_a, rectifier_out_b;
  drive_t gates;
  int error_cnt = 0;
  int cmp_count = 0;
  int hi[6];
  int d1, d2, d1r, d2r, both, trg_n, trg_ov;

  always #5 sys_clk = ~sys_clk;
  assign gates = {leg_one_out_a, leg_one_out_b, leg_two_out_a, leg_two_out_b,
                  rectifier_out_a, rectifier_out_b};

  phase_shift_bridge_pwm_trip i_dut (.sys_clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
    .adc_data, .adc_index, .adc_valid, .comp_trip, .dac_level, .conversion_trigger_a,
    .count_zero_event, .leg_one_out_a, .leg_one_out_b, .leg_two_out_a, .leg_two_out_b,
    .rectifier_out_a, .rectifier_out_b);

  converter_model #(.V_RAW(V_RAW)) i_model (.sys_clk, .resetn,
    .trigger(conversion_trigger_a), .gates, .adc_data, .adc_index, .adc_valid,
    .shoot_through(shoot));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_reg(input logic [7:0] a);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
  endtask : rd_reg

  task wait_zero(output int n);
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end
    while (count_zero_event !== 1'b1 && n < 1100);
    chk(32'(count_zero_event), 32'd1);
  endtask : wait_zero

  // one full period of drive activity
  task measure;
    int n;
    drive_t p;
    wait_zero(n);
    hi = '{default: 0};
    {d1, d2, d1r, d2r, both, trg_n, trg_ov} = '0;
    p = gates;
    repeat (1000)
    begin
      for (int j = 0; j < 6; j++)
        hi[j] += int'(gates[j]);
      d1 += int'(gates[5] & gates[2]);
      d2 += int'(gates[4] & gates[3]);
      d1r += int'((gates[5] & gates[2]) & !(p[5] & p[2]));
      d2r += int'((gates[4] & gates[3]) & !(p[4] & p[3]));
      both += int'((gates[5] & gates[4]) | (gates[3] & gates[2]));
      if (conversion_trigger_a === 1'b1)
      begin
        trg_n++;
        trg_ov += int'((gates[5] & gates[2]) | (gates[4] & gates[3]));
      end
      p = gates;
      @(negedge sys_clk);
    end
  endtask : measure

  task do_reset;
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
  endtask : do_reset

  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    logic [7:0] ra [7];
    logic [31:0] re [7];
    logic [23:0] cmds [3];
    logic [33:0] prod;
    int n, k, ex, prev_ex, prev_d1, bad;
    ra = '{OFS_CTRL, OFS_PHASE, OFS_DB_AP, OFS_DB_PA, OFS_TRIP_DAC, OFS_GAIN, 8'h30};
    re = '{32'h0, 32'h0, 32'h0014, 32'h0014, 32'h0200, 32'h0100, 32'h0};
    cmds = '{24'h20_0000, 24'h80_0000, 24'hff_fe00};
    prev_ex = 0;
    prev_d1 = 0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    for (k = 0; k < 7; k++)
    begin
      rd_reg(ra[k]);
      chk(rv, re[k]);
    end
    chk(32'(dac_level), 32'h0200);
    wr_reg(OFS_TRIP_DAC, 32'h0000_0155);
    wr_reg(8'h30, 32'h0000_ffff);
    rd_reg(8'h30);
    chk(rv, 32'h0);
    chk(32'(dac_level), 32'h0155);
    wait_zero(n);
    wait_zero(n);
    chk(32'(n), 32'd1000);
    $display("test registers done");

    wr_reg(OFS_DB_AP, 32'h0000_000a);
    wr_reg(OFS_DB_PA, 32'h0000_001e);
    for (k = 0; k < 3; k++)
    begin
      prod = 34'(cmds[k]) * 34'(PERIOD_VALUE);
      ex = int'(prod >> PHASE_SHIFT);
      wait_zero(n);
      wr_reg(OFS_PHASE, 32'(cmds[k]));
      rd_reg(OFS_OFFSET);
      chk(32'(rv[9:0]), 32'(prev_ex));
      wait_zero(n);
      wait_zero(n);
      rd_reg(OFS_OFFSET);
      chk(32'(rv[9:0]), 32'(ex));
      chk(32'(rv[25:16]), 32'(ex / 2));
      measure();
      chk(32'(d1 > prev_d1), 32'd1);
      chk(32'(d1r), 32'd1);
      chk(32'(d2r), 32'd1);
      chk(32'(both), 32'd0);
      chk(32'(trg_n), 32'd1);
      chk(32'(trg_ov), 32'd1);
      chk(32'(hi[5]), 32'd490);
      chk(32'(hi[4]), 32'd490);
      chk(32'(hi[3]), 32'd470);
      prev_ex = ex;
      prev_d1 = d1;
    end
    rd_reg(OFS_FEEDBACK);
    chk(rv, {8'h00, V_RAW, 12'h000});
    $display("test phase done");

    for (k = 0; k < 3; k++)
    begin
      wr_reg(OFS_CTRL, 32'(k));
      wait_zero(n);
      measure();
      if (k == 0)
        chk(32'(hi[1] + hi[0]), 32'd0);
      else if (k == 1)
        chk(32'(hi[1] > 0 && hi[1] <= d1 + 40), 32'd1);
      else
        chk(32'(hi[1] < 1000 && 1000 - hi[1] <= d2 + 40), 32'd1);
    end
    chk(32'(shoot), 32'd0);
    wr_reg(OFS_IREF, 32'h00ff_ffff);
    wr_reg(OFS_CTRL, 32'h0000_000e);
    repeat (4) wait_zero(n);
    rd_reg(OFS_OFFSET);
    prod = 34'(PHASE_MAX) * 34'(PERIOD_VALUE);
    chk(32'(rv[9:0]), 32'(prod >> PHASE_SHIFT));
    $display("test rectifier done");

    @(posedge sys_clk);
    comp_trip <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(32'(gates), 32'd0);
    comp_trip <= 1'b0;
    bad = 0;
    repeat (2000)
    begin
      @(negedge sys_clk);
      if (gates !== 6'h00)
        bad++;
    end
    chk(32'(bad), 32'd0);
    rd_reg(OFS_STATUS);
    chk(32'(rv[0]), 32'd1);
    do_reset();
    rd_reg(OFS_STATUS);
    chk(32'(rv[0]), 32'd0);
    measure();
    chk(32'(hi[5]), 32'd480);
    $display("test trip done");
    end_sim();
  end

  initial
  begin
    #600_000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end
endmodule : tb
